// ---- psptm_cfg.svh ----
// constants for the payload serial telemetry mux
`ifndef PSPTM_CFG_SVH
`define PSPTM_CFG_SVH
`define PSPTM_NUM_CH 2
`define PSPTM_MAX_RATE_BPS 2000
`define PSPTM_FRAME_BITS 32
`define PSPTM_FRAME_LAST 5'h1F
`define PSPTM_SYNC_WORD 8'hB8
`define PSPTM_ACQ_FILL 8'h00
`define PSPTM_FIELD_BITS 5
`define PSPTM_FIELD_MAX 3'h5
`define PSPTM_BIT_DIV 16
`define PSPTM_FIFO_DEPTH 8
`endif

// ---- psptm_pkg.sv ----
// types shared by the payload serial telemetry mux
package psptm_pkg;
  typedef enum logic [0:0] {
    PSPTM_ST_IDLE = 1'b0,
    PSPTM_ST_RUN = 1'b1
  } psptm_state_e;
  typedef logic [7:0] psptm_word_t;
endpackage

// ---- psptm_chan_rx.sv ----
// one payload channel: capture on the payload clock, gray fifo into ref_clk
`timescale 1ns/1ps
`include "psptm_cfg.svh"
module psptm_chan_rx #(
  parameter int DEPTH = `PSPTM_FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic pc_clk_in,
  input wire logic pc_data_in,
  output logic bit_valid_out,
  output logic bit_data_out,
  input wire logic bit_pop_in,
  output logic overrun_out
);
  import psptm_pkg::*;
  logic [1:0] lrst_q;
  logic [AW:0] wbin_q;
  logic [AW:0] wgray_q;
  logic [AW:0] rg_s1_q;
  logic [AW:0] rg_s2_q;
  logic [AW:0] wg_s1_q;
  logic [AW:0] wg_s2_q;
  logic [AW:0] rbin_q;
  logic [AW:0] rgray_q;
  logic [AW:0] wbin_inc;
  logic [AW:0] rbin_inc;
  logic ovr_l_q;
  logic [1:0] ovr_s_q;
  logic full;
  logic empty;
  logic mem [DEPTH];

  // reset reaches the link domain only while the payload clock runs
  always_ff @(posedge pc_clk_in) begin
    lrst_q <= {lrst_q[0], srst_in};
  end

  assign wbin_inc = wbin_q + 1'b1;
  assign full = (wgray_q == {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]});

  always_ff @(posedge pc_clk_in) begin
    rg_s1_q <= rgray_q;
    rg_s2_q <= rg_s1_q;
  end

  // one sample per leading edge while the fifo is not full, straight from the pin
  always_ff @(posedge pc_clk_in) begin
    if (!full) begin
      mem[wbin_q[AW-1:0]] <= pc_data_in;
    end
  end

  always_ff @(posedge pc_clk_in) begin
    if (lrst_q[1]) begin
      wbin_q <= '0;
      wgray_q <= '0;
    end else if (!full) begin
      wbin_q <= wbin_inc;
      wgray_q <= (wbin_inc >> 1) ^ wbin_inc;
    end
  end

  // only reachable when the payload runs faster than allowed
  always_ff @(posedge pc_clk_in) begin
    if (lrst_q[1]) begin
      ovr_l_q <= 1'b0;
    end else if (full) begin
      ovr_l_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    wg_s1_q <= wgray_q;
    wg_s2_q <= wg_s1_q;
    ovr_s_q <= {ovr_s_q[0], ovr_l_q};
  end

  assign overrun_out = ovr_s_q[1];
  assign empty = (rgray_q == wg_s2_q);
  assign rbin_inc = rbin_q + 1'b1;
  assign bit_valid_out = !empty;
  assign bit_data_out = mem[rbin_q[AW-1:0]];

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rbin_q <= '0;
      rgray_q <= '0;
    end else if (bit_pop_in && !empty) begin
      rbin_q <= rbin_inc;
      rgray_q <= (rbin_inc >> 1) ^ rbin_inc;
    end
  end

  AST_FULL_HOLDS: assert property (@(posedge pc_clk_in) disable iff (lrst_q[1])
    full |=> wbin_q == $past(wbin_q)) else $error("write pointer moved while full");
  AST_SAMPLE_EDGE: assert property (@(posedge pc_clk_in) disable iff (lrst_q[1])
    !full |=> mem[$past(wbin_q[AW-1:0])] == $past(pc_data_in))
    else $error("payload bit not captured at clock edge");
  AST_READ_ADVANCE: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    bit_pop_in && !empty |=> rbin_q == $past(rbin_q) + 1'b1)
    else $error("read pointer did not step on pop");
  COV_OVERRUN: cover property (@(posedge ref_clk_in) disable iff (srst_in) $rose(overrun_out));
endmodule // psptm_chan_rx

// ---- psptm_mux.sv ----
// pcm framer merging two payload serial channels with acquisition words
`timescale 1ns/1ps
`include "psptm_cfg.svh"
module psptm_mux #(
  parameter int BIT_DIV = `PSPTM_BIT_DIV,
  parameter int FIFO_DEPTH = `PSPTM_FIFO_DEPTH
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic pc0_clk_in,
  input wire logic pc0_data_in,
  input wire logic pc1_clk_in,
  input wire logic pc1_data_in,
  input wire psptm_pkg::psptm_word_t acq_data_in,
  input wire logic acq_valid_in,
  output logic acq_ready_out,
  output logic pcm_data_out,
  output logic pcm_clk_out,
  output logic pcm_frame_out,
  output logic [`PSPTM_NUM_CH-1:0] overrun_out
);
  import psptm_pkg::*;
  localparam int NCH = `PSPTM_NUM_CH;
  localparam int FB = `PSPTM_FIELD_BITS;
  localparam logic [15:0] DIV_LAST = 16'(BIT_DIV - 1);
  localparam logic [15:0] DIV_HALF = 16'(BIT_DIV / 2);

  psptm_state_e state_q;
  logic [15:0] div_q;
  logic [15:0] div_d;
  logic [4:0] idx_q;
  logic [`PSPTM_FRAME_BITS-1:0] shift_q;
  logic [`PSPTM_FRAME_BITS-1:0] frame_w;
  logic frame_q;
  logic clk_q;
  logic tick;
  logic load;
  logic [NCH-1:0] pc_clk_w;
  logic [NCH-1:0] pc_data_w;
  logic [NCH-1:0] bvalid;
  logic [NCH-1:0] bdata;
  logic [NCH-1:0] pop;
  logic [2:0] cnt_q [NCH];
  logic [FB-1:0] bits_q [NCH];
  psptm_word_t acq_field;

  assign pc_clk_w = {pc1_clk_in, pc0_clk_in};
  assign pc_data_w = {pc1_data_in, pc0_data_in};

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      psptm_chan_rx #(
        .DEPTH(FIFO_DEPTH)
      ) u_rx (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .pc_clk_in(pc_clk_w[g]),
        .pc_data_in(pc_data_w[g]),
        .bit_valid_out(bvalid[g]),
        .bit_data_out(bdata[g]),
        .bit_pop_in(pop[g]),
        .overrun_out(overrun_out[g])
      );
      // a bit leaves the fifo only when the field has room for it
      assign pop[g] = bvalid[g] && (cnt_q[g] < `PSPTM_FIELD_MAX) && !load;
    end
  endgenerate

  assign tick = (div_q == DIV_LAST);
  assign div_d = tick ? 16'h0000 : div_q + 16'h0001;
  assign load = tick && ((state_q == PSPTM_ST_IDLE) || (idx_q == `PSPTM_FRAME_LAST));
  assign acq_ready_out = load;
  assign acq_field = acq_valid_in ? acq_data_in : `PSPTM_ACQ_FILL;
  // field = bit count then bits, oldest bit highest of the counted ones
  assign frame_w = {`PSPTM_SYNC_WORD, cnt_q[0], bits_q[0], cnt_q[1], bits_q[1],
                    acq_field};

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      div_q <= 16'h0000;
      clk_q <= 1'b0;
    end else begin
      div_q <= div_d;
      clk_q <= (div_d >= DIV_HALF);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_q <= PSPTM_ST_IDLE;
    end else begin
      case (state_q)
        PSPTM_ST_IDLE: if (tick) state_q <= PSPTM_ST_RUN;
        PSPTM_ST_RUN: state_q <= PSPTM_ST_RUN;
        default: state_q <= PSPTM_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      idx_q <= 5'h00;
      shift_q <= '0;
      frame_q <= 1'b0;
    end else if (load) begin
      idx_q <= 5'h00;
      shift_q <= frame_w;
      frame_q <= 1'b1;
    end else if (tick) begin
      idx_q <= idx_q + 5'h01;
      shift_q <= {shift_q[`PSPTM_FRAME_BITS-2:0], 1'b0};
      frame_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < NCH; i++) begin
      if (srst_in || load) begin
        cnt_q[i] <= 3'h0;
        bits_q[i] <= '0;
      end else if (pop[i]) begin
        cnt_q[i] <= cnt_q[i] + 3'h1;
        bits_q[i] <= {bits_q[i][FB-2:0], bdata[i]};
      end
    end
  end

  assign pcm_data_out = shift_q[`PSPTM_FRAME_BITS-1];
  assign pcm_clk_out = clk_q;
  assign pcm_frame_out = frame_q;

  AST_FIELD_LIMIT: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    cnt_q[0] <= `PSPTM_FIELD_MAX && cnt_q[1] <= `PSPTM_FIELD_MAX)
    else $error("payload field overfilled");
  AST_POP_ORDER: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    pop[0] |=> bits_q[0][0] == $past(bdata[0]) && bits_q[0][FB-1:1] == $past(bits_q[0][FB-2:0]))
    else $error("channel 0 bit order broken");
  AST_CH1_SLOT: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    load |=> shift_q[15:8] == {$past(cnt_q[1]), $past(bits_q[1])})
    else $error("channel 1 field not placed in frame");
  AST_ACQ_SLOT: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    acq_valid_in && acq_ready_out |=> shift_q[7:0] == $past(acq_data_in) && pcm_frame_out)
    else $error("acquisition word not merged");
  AST_SYNC_FIRST: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    $rose(pcm_frame_out) |-> pcm_data_out == 1'b1 ##1 pcm_frame_out [*3])
    else $error("frame does not open with sync bit");
  AST_NO_POP_AT_LOAD: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    load |-> pop == '0 ##1 cnt_q[0] == 3'h0)
    else $error("bit popped during frame load");

  // serial timing: each bit stands a whole bit period, clock rises mid-bit
  AST_BIT_STANDS: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    !tick |=> $stable(pcm_data_out))
    else $error("pcm bit changed inside its bit period");
  AST_CLK_LOW: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    tick |=> !pcm_clk_out)
    else $error("pcm clock not low at bit start");
  AST_CLK_HIGH: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    div_q == DIV_HALF - 16'h0001 |=> pcm_clk_out)
    else $error("pcm clock not high at mid bit");
  AST_SHIFT_STEP: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    tick && !load |=> pcm_data_out == $past(shift_q[`PSPTM_FRAME_BITS-2]))
    else $error("pcm bits not sent in order");
  AST_IDX_STEP: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    tick && !load |=> idx_q == $past(idx_q) + 5'h01)
    else $error("bit index did not step");

  // frame mark: set by load, gone after one bit period
  AST_MARK_SET: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    load |=> pcm_frame_out)
    else $error("frame mark missing after load");
  AST_MARK_CLEAR: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    tick && !load |=> !pcm_frame_out)
    else $error("frame mark beyond first bit");

  // counts the cycles of one frame mark, so its length can be bounded
  logic [15:0] mark_len_q;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in || !frame_q) begin
      mark_len_q <= 16'h0000;
    end else begin
      mark_len_q <= mark_len_q + 16'h0001;
    end
  end
  AST_MARK_LENGTH: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    frame_q |-> mark_len_q <= DIV_LAST)
    else $error("frame mark longer than one bit period");
  AST_MARK_ENDS: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    frame_q && mark_len_q == DIV_LAST |=> !frame_q)
    else $error("frame mark did not end");

  // frame contents placed by load
  AST_SYNC_WORD: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    load |=> shift_q[31:24] == `PSPTM_SYNC_WORD)
    else $error("sync word not placed in frame");
  AST_CH0_SLOT: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    load |=> shift_q[23:16] == {$past(cnt_q[0]), $past(bits_q[0])})
    else $error("channel 0 field not placed in frame");
  AST_FILL_WORD: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    load && !acq_valid_in |=> shift_q[7:0] == `PSPTM_ACQ_FILL)
    else $error("fill word not sent without acquisition data");

  // field filling: one bit per pop, oldest bit kept highest
  AST_POP_ORDER_CH1: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    pop[1] |=> bits_q[1][0] == $past(bdata[1]) && bits_q[1][FB-1:1] == $past(bits_q[1][FB-2:0]))
    else $error("channel 1 bit order broken");
  AST_COUNT_STEP0: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    pop[0] |=> cnt_q[0] == $past(cnt_q[0]) + 3'h1)
    else $error("channel 0 count did not step");
  AST_COUNT_STEP1: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    pop[1] |=> cnt_q[1] == $past(cnt_q[1]) + 3'h1)
    else $error("channel 1 count did not step");

  COV_FRAME: cover property (@(posedge ref_clk_in) disable iff (srst_in)
    load && idx_q == `PSPTM_FRAME_LAST);
  COV_BOTH_POP: cover property (@(posedge ref_clk_in) disable iff (srst_in) pop[0] && pop[1]);
  COV_FULL_FIELD: cover property (@(posedge ref_clk_in) disable iff (srst_in)
    load && cnt_q[0] == `PSPTM_FIELD_MAX);
endmodule // psptm_mux

// ---- psptm_payload_model.sv ----
// payload craft model: one serial data line with its own companion clock
`timescale 1ns/1ps
module psptm_payload_model #(
  parameter realtime HALF = 32.0
) (
  output logic pc_clk_out,
  output logic pc_data_out
);
  // clock stands low between bursts
  initial begin
    pc_clk_out = 1'b0;
    pc_data_out = 1'b0;
  end
  // data set at the falling edge, so it is settled at the leading edge
  task automatic send(input logic [3:0] b);
    for (int i = 3; i >= 0; i--) begin
      pc_data_out = b[i];
      #(HALF) pc_clk_out = 1'b1;
      #(HALF) pc_clk_out = 1'b0;
    end
    pc_data_out = ~b[0]; // inverted: no stale last bit
  endtask
endmodule // psptm_payload_model

// ---- tb.sv ----
// testbench: two payload channels and acquisition words into the pcm stream
`timescale 1ns/1ps
module tb;
  import psptm_pkg::*;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic acq_valid_in = 1'b0;
  logic chg = 1'b1;
  logic armed = 1'b0;
  psptm_word_t acq_data_in = 8'h00;
  logic pc0_clk, pc0_data, pc1_clk, pc1_data;
  logic acq_ready_out, pcm_data_out, pcm_clk_out, pcm_frame_out;
  logic [1:0] overrun_out;
  logic [31:0] seed = 32'hBF0CB243;
  logic [31:0] w = 32'h0;
  logic [31:0] r;
  logic q0[$];
  logic q1[$];
  psptm_word_t qa[$];
  int fail_count = 0;
  int total_checks = 0;
  int nb = 0;
  always #2 ref_clk_in = ~ref_clk_in;
  psptm_mux #(.BIT_DIV(4)) dut (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .pc0_clk_in(pc0_clk), .pc0_data_in(pc0_data), .pc1_clk_in(pc1_clk),
    .pc1_data_in(pc1_data), .acq_data_in(acq_data_in), .acq_valid_in(acq_valid_in),
    .acq_ready_out(acq_ready_out), .pcm_data_out(pcm_data_out), .pcm_clk_out(pcm_clk_out),
    .pcm_frame_out(pcm_frame_out), .overrun_out(overrun_out));
  psptm_payload_model u_pc0 (.pc_clk_out(pc0_clk), .pc_data_out(pc0_data));
  psptm_payload_model u_pc1 (.pc_clk_out(pc1_clk), .pc_data_out(pc1_data));
  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_field(input logic [7:0] f, input bit ch);
    logic e;
    if (armed) begin
      check("field count", 8'h01, {7'h00, f[7:5] <= 3'h5});
      check("field pad", 8'h00, {3'h0, f[4:0] >> f[7:5]});
      for (int i = int'(f[7:5]) - 1; i >= 0; i--) begin
        if (ch) e = q1.size() ? q1.pop_front() : 1'bx;
        else e = q0.size() ? q0.pop_front() : 1'bx;
        check(ch ? "ch1 bit" : "ch0 bit", {7'h00, e}, {7'h00, f[i]});
      end
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // word held until the load cycle takes it
  always @(negedge ref_clk_in) begin
    if (!srst_in) begin
      if (acq_ready_out === 1'b1) begin
        qa.push_back(acq_valid_in ? acq_data_in : 8'h00);
        chg = 1'b1;
      end else if (chg) begin
        r = next_rand();
        acq_data_in = r[7:0];
        acq_valid_in = r[8];
        chg = 1'b0;
      end
    end
  end
  // mid-bit sampling on the pcm clock rise
  always @(posedge pcm_clk_out) begin
    if (pcm_frame_out === 1'b1) begin
      if (nb != 0 && armed) check("frame len", 8'd32, nb[7:0]);
      nb = 0;
    end
    w = {w[30:0], pcm_data_out};
    nb++;
    if (nb == 32) begin
      check("sync", 8'hB8, w[31:24]);
      check("acq word", qa.size() ? qa.pop_front() : 8'hxx, w[7:0]);
      check_field(w[23:16], 1'b0);
      check_field(w[15:8], 1'b1);
    end
  end
  initial begin
    // payload clocks must run during reset to clear the link side
    fork u_pc0.send(4'h0); u_pc1.send(4'h0); join
    @(negedge ref_clk_in);
    srst_in = 1'b0;
    fork u_pc0.send(4'h0); u_pc1.send(4'h0); join
    #3000 armed = 1'b1;
    $display("reset test done");
    // bursts at 64 ns clocks, gaps keep the average rate low
    repeat (24) begin
      r = next_rand();
      for (int i = 3; i >= 0; i--) begin
        q0.push_back(r[i]);
        q1.push_back(r[i + 4]);
      end
      fork u_pc0.send(r[3:0]); begin #5.3 u_pc1.send(r[7:4]); end join
      #(600.3 + r[16:10]);
    end
    #3000;
    check("ch0 left", 8'h00, 8'(q0.size()));
    check("ch1 left", 8'h00, 8'(q1.size()));
    check("overrun", 8'h00, {6'h00, overrun_out});
    $display("stream test done");
    complete_run();
  end
  initial begin
    #100000;
    fail_count++;
    complete_run();
  end
endmodule // tb
